// ---- nvc_pkg.sv ----
/*
 * Package of constants for the nonvolatile save/load control block.
 * Assumes the register addresses are 12 bits wide and the data is 8 bits wide.
 */
package nvc_pkg;

    // =====================================================================
    // Register addresses
    // =====================================================================
    localparam logic [11:0] NVC_ADDR_STATUS = 12'hb00; // Transfer-pending status.
    localparam logic [11:0] NVC_ADDR_ERROR = 12'hb01; // Data-error flag.
    localparam logic [11:0] NVC_ADDR_CONTROL = 12'hb02; // Unlock and soft reload.
    localparam logic [11:0] NVC_ADDR_SAVE = 12'hb03; // Save start.

    // =====================================================================
    // Field positions and reset values
    // =====================================================================
    localparam int NVC_BIT_BUSY = 0; // Pending flag in the status register.
    localparam int NVC_BIT_ERR = 0; // Error flag in the error register.
    localparam int NVC_BIT_UNLOCK = 0; // Write-protect removal in control.
    localparam int NVC_BIT_SOFT = 1; // Soft reload in control.
    localparam int NVC_BIT_SAVE = 0; // Save start in the save register.
    localparam int NVC_BIT_OPCODE = 7; // Command byte kind: 1 for an operation code.
    localparam logic NVC_UNLOCK_RST = 1'b0; // Store is write-protected after reset.

    // =====================================================================
    // Command list layout
    // =====================================================================
    localparam logic [7:0] NVC_SEG_FIRST = 8'h00; // First entry of the command list.
    localparam logic [7:0] NVC_SEG_STEP = 8'h01; // Step between list bytes.
    localparam logic [6:0] NVC_CNT_LAST = 7'h00; // Count value of the final byte.
    localparam logic [15:0] NVC_ADDR_STEP = 16'h0001; // Step between register addresses.

    // =====================================================================
    // Sequencer states
    // =====================================================================
    typedef enum logic [5:0] {
        NVC_ST_IDLE = 6'b000001,
        NVC_ST_CMD = 6'b000010,
        NVC_ST_AHI = 6'b000100,
        NVC_ST_ALO = 6'b001000,
        NVC_ST_XFER = 6'b010000,
        NVC_ST_COMMIT = 6'b100000
    } nvc_state_t;

endpackage

// ---- nvc_eeprom_ctrl.sv ----
/*
 * Save/load sequencer and control registers for the nonvolatile store.
 * Assumes a synchronous internal register port from the serial control port,
 * a command list read combinationally at seg_addr_o, and a store that answers
 * each byte request with a one-cycle ack.
 */
`timescale 1ns/1ns

module nvc_eeprom_ctrl
    import nvc_pkg::*;
#(
    parameter logic [7:0] OP_COMMIT = 8'h80, // Operation code for commit to active.
    parameter logic [7:0] OP_END = 8'hff // Operation code for end of data.
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Register port.
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Pins and configuration.
    input wire logic nv_load_pin_n_i,
    input wire logic status_sel_i,
    output logic status_pin_o,
    output logic soft_reset_o,
    // Command list read port.
    output logic [7:0] seg_addr_o,
    input wire logic [7:0] seg_data_i,
    // Nonvolatile store byte port.
    output logic nv_req_o,
    output logic nv_save_o,
    output logic [15:0] nv_reg_addr_o,
    input wire logic nv_ack_i,
    input wire logic nv_err_i,
    // Commit of buffer to active registers.
    output logic commit_o
);

    // =====================================================================
    // Declarations
    // =====================================================================
    nvc_state_t state_reg; // Sequencer state.
    nvc_state_t state_next; // Next sequencer state.
    logic busy_reg; // Transfer pending.
    logic err_reg; // Sticky data error of the last transfer.
    logic unlock_reg; // Write protection removed.
    logic save_reg; // Current transfer is a save.
    logic [6:0] cnt_reg; // Bytes left minus one in this entry.
    logic start_save; // Accepted save request.
    logic start_load; // Accepted soft reload request.

    // Returns true for a write to the given register.
    function automatic logic wr_hit(input logic [11:0] a);
        wr_hit = reg_wr_i && (reg_addr_i == a);
    endfunction

    // Requests are taken only while idle; the host is trusted to pace them.
    assign start_save = wr_hit(NVC_ADDR_SAVE) && reg_wdata_i[NVC_BIT_SAVE] && unlock_reg
                        && (state_reg == NVC_ST_IDLE);
    assign start_load = wr_hit(NVC_ADDR_CONTROL) && reg_wdata_i[NVC_BIT_SOFT] && !nv_load_pin_n_i
                        && (state_reg == NVC_ST_IDLE);

    // =====================================================================
    // Sequencer
    // =====================================================================
    // Walks the command list one entry at a time.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            NVC_ST_IDLE: begin
                if (start_save || start_load) begin
                    state_next = NVC_ST_CMD;
                end
            end
            NVC_ST_CMD: begin
                if (!seg_data_i[NVC_BIT_OPCODE]) begin
                    state_next = NVC_ST_AHI;
                end else if (seg_data_i == OP_COMMIT) begin
                    state_next = NVC_ST_COMMIT;
                end else begin
                    state_next = NVC_ST_IDLE; // End of data, or an unknown code, stops.
                end
            end
            NVC_ST_AHI: begin
                state_next = NVC_ST_ALO;
            end
            NVC_ST_ALO: begin
                state_next = NVC_ST_XFER;
            end
            NVC_ST_XFER: begin
                if (nv_ack_i && (cnt_reg == NVC_CNT_LAST)) begin
                    state_next = NVC_ST_CMD;
                end
            end
            NVC_ST_COMMIT: begin
                state_next = NVC_ST_CMD;
            end
        endcase
    end

    // State register and the pending flag derived from it.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= NVC_ST_IDLE;
            busy_reg <= 1'b0;
            status_pin_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg <= (state_next != NVC_ST_IDLE);
            status_pin_o <= status_sel_i && (state_next != NVC_ST_IDLE);
        end
    end

    // Command list pointer, byte count and register address.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            seg_addr_o <= NVC_SEG_FIRST;
            cnt_reg <= NVC_CNT_LAST;
            nv_reg_addr_o <= '0;
        end else begin
            if (state_reg == NVC_ST_IDLE) begin
                seg_addr_o <= NVC_SEG_FIRST;
            end else if (state_reg == NVC_ST_CMD || state_reg == NVC_ST_AHI || state_reg == NVC_ST_ALO) begin
                // Only list bytes that were consumed advance the pointer; commit already moved past its code.
                seg_addr_o <= seg_addr_o + NVC_SEG_STEP;
            end
            if (state_reg == NVC_ST_CMD) begin
                cnt_reg <= seg_data_i[6:0];
            end else if (state_reg == NVC_ST_XFER && nv_ack_i) begin
                cnt_reg <= cnt_reg - 7'h01;
            end
            if (state_reg == NVC_ST_AHI) begin
                nv_reg_addr_o <= {seg_data_i, nv_reg_addr_o[7:0]}; // Most significant byte first.
            end else if (state_reg == NVC_ST_ALO) begin
                nv_reg_addr_o <= {nv_reg_addr_o[15:8], seg_data_i};
            end else if (state_reg == NVC_ST_XFER && nv_ack_i) begin
                nv_reg_addr_o <= nv_reg_addr_o + NVC_ADDR_STEP;
            end
        end
    end

    // Store requests, direction and the commit and soft reset pulses.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nv_req_o <= 1'b0;
            save_reg <= 1'b0;
            commit_o <= 1'b0;
            soft_reset_o <= 1'b0;
        end else begin
            nv_req_o <= (state_next == NVC_ST_XFER);
            commit_o <= (state_next == NVC_ST_COMMIT);
            soft_reset_o <= start_load;
            if (start_save) begin
                save_reg <= 1'b1;
            end else if (start_load) begin
                save_reg <= 1'b0;
            end
        end
    end
    assign nv_save_o = save_reg;

    // =====================================================================
    // Control and error registers
    // =====================================================================
    // Unlock bit is the only stored control bit; the soft bit starts a reload, writes to other bits drop.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unlock_reg <= NVC_UNLOCK_RST;
        end else if (wr_hit(NVC_ADDR_CONTROL)) begin
            unlock_reg <= reg_wdata_i[NVC_BIT_UNLOCK];
        end
    end

    // Error clears when a transfer starts; a bad byte sets it and wins.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_reg <= 1'b0;
        end else if (state_reg == NVC_ST_XFER && nv_ack_i && nv_err_i) begin
            err_reg <= 1'b1;
        end else if (start_save || start_load) begin
            err_reg <= 1'b0;
        end
    end

    // Read data; self-clearing bits show 1 while their transfer runs.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= 8'h00;
            unique case (reg_addr_i)
                NVC_ADDR_STATUS: reg_rdata_o[NVC_BIT_BUSY] <= busy_reg;
                NVC_ADDR_ERROR: reg_rdata_o[NVC_BIT_ERR] <= err_reg;
                NVC_ADDR_CONTROL: begin
                    reg_rdata_o[NVC_BIT_UNLOCK] <= unlock_reg;
                    reg_rdata_o[NVC_BIT_SOFT] <= busy_reg && !save_reg;
                end
                NVC_ADDR_SAVE: reg_rdata_o[NVC_BIT_SAVE] <= busy_reg && save_reg;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_busy_tracks_state: assert property (busy_reg == (state_reg != NVC_ST_IDLE))
        else $error("pending flag differs from sequencer");
    a_pin_route: assert property (status_pin_o == (status_sel_i && busy_reg) || $changed(status_sel_i))
        else $error("status pin not routed");
    a_err_sets: assert property (state_reg == NVC_ST_XFER && nv_ack_i && nv_err_i |=> err_reg)
        else $error("error flag not set");
    a_ro_status: assert property (wr_hit(NVC_ADDR_ERROR) && !busy_reg |=> $stable(err_reg))
        else $error("error flag changed by write");
    a_soft_gated: assert property (wr_hit(NVC_ADDR_CONTROL) && reg_wdata_i[NVC_BIT_SOFT]
        && nv_load_pin_n_i |=> !soft_reset_o)
        else $error("soft reload with pin high");
    a_soft_pulse: assert property (soft_reset_o |-> busy_reg ##1 !soft_reset_o)
        else $error("soft reset not one pulse with load");
    a_save_locked: assert property (!unlock_reg && !busy_reg && wr_hit(NVC_ADDR_SAVE) |=> !busy_reg)
        else $error("save started while protected");
    a_save_starts: assert property (start_save |=> busy_reg && save_reg && state_reg == NVC_ST_CMD)
        else $error("save not started");
    a_save_clears: assert property (busy_reg && save_reg && state_next == NVC_ST_IDLE |=> !busy_reg)
        else $error("save bit not cleared");
    a_end_stops: assert property (state_reg == NVC_ST_CMD && seg_data_i == OP_END
        |=> state_reg == NVC_ST_IDLE)
        else $error("end code did not stop");
    a_entry_addr: assert property (state_reg == NVC_ST_CMD && !seg_data_i[NVC_BIT_OPCODE]
        |=> ##2 nv_req_o)
        else $error("data entry did not request");

    c_save_done: cover property (start_save ##[1:200] !busy_reg);
    c_load_done: cover property (start_load ##[1:200] !busy_reg);
    c_commit: cover property (commit_o);
    c_error: cover property (err_reg && !busy_reg);

endmodule

// ---- nvc_store_model.sv ----
/*
 * Partner model: the command list and the nonvolatile store behind the block.
 * Assumes one clock and the byte handshake of the save/load sequencer.
 */
`timescale 1ns/1ns

module nvc_store_model (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Command list.
    input wire logic [7:0] seg_addr_i,
    output logic [7:0] seg_data_o,
    // Store byte port.
    input wire logic nv_req_i,
    input wire logic [15:0] nv_reg_addr_i,
    input wire logic err_en_i,
    output logic nv_ack_o,
    output logic nv_err_o
);
    // =====================================================================
    // Storage
    // =====================================================================
    logic [7:0] mem [0:255]; // Filled by the bench; an end code closes every list.
    logic [15:0] seen [$]; // Register addresses of acknowledged bytes.
    int unsigned wait_cnt; // Cycles left before the next answer.

    // The list is read combinationally, as the sequencer expects.
    assign seg_data_o = mem[seg_addr_i];
    // A bad byte is only ever reported together with its answer.
    assign nv_err_o = nv_ack_o & err_en_i;

    // Answers each byte after a random delay of 0 to 3 cycles.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nv_ack_o <= 1'b0;
            wait_cnt <= 0;
        end else if (nv_ack_o) begin
            nv_ack_o <= 1'b0; // One-cycle pulse, then a fresh delay.
            wait_cnt <= $urandom_range(3);
        end else if (nv_req_i && wait_cnt == 0) begin
            nv_ack_o <= 1'b1;
            seen.push_back(nv_reg_addr_i);
        end else if (wait_cnt != 0) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

// ---- tb_eeprom_save_load_control.sv ----
/*
 * Self-checking bench for the save/load control registers and sequencer.
 * Assumes the store model answers bytes and holds the command list.
 */
`timescale 1ns/1ns

module tb_eeprom_save_load_control;
    import nvc_pkg::*;
    // =====================================================================
    // Signals
    // =====================================================================
    logic clk_sys_i = 1'b0, resetn_i = 1'b0; // Clock and reset.
    logic [11:0] reg_addr_i = 12'h000; // Register port inputs.
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, nv_load_pin_n_i = 1'b1, status_sel_i = 1'b0, err_en = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, seg_addr_o, seg_data_i, rd_v;
    logic status_pin_o, soft_reset_o, nv_req_o, nv_save_o, nv_ack_i, nv_err_i, commit_o;
    logic [15:0] nv_reg_addr_o, base;
    int n_errors = 0, n_compared = 0, n_soft = 0, n_commit = 0, cnt;

    nvc_eeprom_ctrl dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .nv_load_pin_n_i(nv_load_pin_n_i), .status_sel_i(status_sel_i), .status_pin_o(status_pin_o),
        .soft_reset_o(soft_reset_o), .seg_addr_o(seg_addr_o), .seg_data_i(seg_data_i), .nv_req_o(nv_req_o),
        .nv_save_o(nv_save_o), .nv_reg_addr_o(nv_reg_addr_o), .nv_ack_i(nv_ack_i), .nv_err_i(nv_err_i),
        .commit_o(commit_o));
    nvc_store_model m (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .seg_addr_i(seg_addr_o),
        .seg_data_o(seg_data_i), .nv_req_i(nv_req_o), .nv_reg_addr_i(nv_reg_addr_o), .err_en_i(err_en),
        .nv_ack_o(nv_ack_i), .nv_err_o(nv_err_i));

    // Clock at 100 MHz.
    always #5 clk_sys_i = ~clk_sys_i;
    // Counts the one-cycle pulses of reload and commit.
    always @(posedge clk_sys_i) begin
        if (soft_reset_o === 1'b1) n_soft++;
        if (commit_o === 1'b1) n_commit++;
    end

    // =====================================================================
    // Tasks
    // =====================================================================
    // Compares one value with its expectation.
    task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
        n_compared++;
        if (seen_v !== exp_v) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask
    // One register write strobe.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(posedge clk_sys_i);
        #1 reg_wr_i = 1'b0;
    endtask
    // One register read; data is taken the cycle after the strobe.
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        #1 reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(posedge clk_sys_i);
        #1 reg_rd_i = 1'b0;
        d = reg_rdata_o;
    endtask
    // Polls the pending flag, bounded.
    task automatic wait_idle;
        for (int i = 0; i < 300; i++) begin
            rd(NVC_ADDR_STATUS, rd_v);
            if (rd_v[0] === 1'b0) return;
        end
        n_errors++;
    endtask
    // Expected address of the k-th byte of the list built below.
    function automatic logic [15:0] exp_addr(input int k);
        return (k <= cnt) ? base + 16'(k) : 16'h0200;
    endfunction
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length of a few thousand cycles.
    initial begin
        #500000;
        n_errors++;
        tally_and_finish();
    end

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        void'($urandom(15));
        for (int i = 0; i < 256; i++) m.mem[i] = 8'hff;
        repeat (10) @(posedge clk_sys_i);
        #1 resetn_i = 1'b1;
        // Reset values, plus one unmapped address.
        for (int a = 0; a < 5; a++) begin
            rd(12'hb00 + 12'(a), rd_v);
            check(16'(rd_v), 16'h0000);
        end
        // A save is refused while the store is protected.
        wr(NVC_ADDR_SAVE, 8'h01);
        check(16'(nv_save_o), 16'h0000);
        // Pin high, soft bit clear: only the unlock bit lands, unused bits stay zero.
        wr(NVC_ADDR_CONTROL, 8'hfd);
        rd(NVC_ADDR_CONTROL, rd_v);
        check(16'(rd_v), 16'h0001);
        check(16'(n_soft), 16'h0000);
        status_sel_i = 1'b1;
        // Two saves with random list contents; the second reports bad data.
        for (int p = 0; p < 2; p++) begin
            cnt = $urandom_range(3);
            base = 16'($urandom);
            m.mem[0] = {1'b0, 7'(cnt)};
            m.mem[1] = base[15:8];
            m.mem[2] = base[7:0];
            m.mem[3] = 8'h80;
            m.mem[4] = 8'h00;
            m.mem[5] = 8'h02;
            m.mem[6] = 8'h00;
            m.mem[7] = 8'hff;
            m.seen.delete();
            err_en = p[0];
            n_commit = 0;
            wr(NVC_ADDR_SAVE, 8'hff);
            check(16'(nv_save_o), 16'h0001);
            check(16'(status_pin_o), 16'h0001);
            rd(NVC_ADDR_STATUS, rd_v);
            check(16'(rd_v), 16'h0001);
            rd(NVC_ADDR_SAVE, rd_v);
            check(16'(rd_v), 16'h0001);
            wait_idle();
            check(16'(status_pin_o), 16'h0000);
            check(16'(m.seen.size()), 16'(cnt + 2));
            foreach (m.seen[k]) check(m.seen[k], exp_addr(k));
            check(16'(n_commit), 16'h0001);
            rd(NVC_ADDR_SAVE, rd_v);
            check(16'(rd_v), 16'h0000);
            wr(NVC_ADDR_ERROR, 8'h00);
            rd(NVC_ADDR_ERROR, rd_v);
            check(16'(rd_v), 16'(p));
            repeat (1000) @(posedge clk_sys_i); // Gap between transfers.
            #1;
        end
        // Soft reload with the load pin low runs a load and clears itself.
        err_en = 1'b0;
        nv_load_pin_n_i = 1'b0;
        wr(NVC_ADDR_CONTROL, 8'h03);
        check(16'(nv_save_o), 16'h0000);
        rd(NVC_ADDR_CONTROL, rd_v);
        check(16'(rd_v), 16'h0003);
        wait_idle();
        check(16'(n_soft), 16'h0001);
        rd(NVC_ADDR_CONTROL, rd_v);
        check(16'(rd_v), 16'h0001);
        rd(NVC_ADDR_ERROR, rd_v);
        check(16'(rd_v), 16'h0000);
        tally_and_finish();
    end
endmodule
